// >>> hdl/tmw_pkg.sv
// constants, enums and carrier structs of the 8-bit waveform timer
// Summary of operation
// - Mode 0 only counts up and wraps from 0xFF to 0x00
// - Normal mode sets overflow flag as the count becomes zero; counting never clears it
// - Mode 2 clears the counter when it matches compare A
// - Clear-on-match mode uses compare A writes at once; a missed match wraps
// - Clear-on-match mode with A code 1 toggles output A per match
// - Clear-on-match mode sets overflow flag on the 0xFF to 0x00 step
// - Modes 3 and 7 are fast PWM, top 0xFF or compare A
// - Fast PWM counts up to top, then clears on the next tick
// - Fast PWM code 2 clears on match and sets at bottom; code 3 inverts
// - Fast PWM sets overflow flag each time the counter reaches top
// - PWM code 1 toggles only output A, and only with mode high bit set
// - Fast PWM compare zero gives one-tick spike; compare max holds output steady
// - Fast PWM compare values are double buffered, toggle mode included
// - Modes 1 and 5 are phase-correct PWM, top 0xFF or compare A
// - Phase-correct counts up, holds top one tick, then counts down
// - Phase-correct code 2 clears on up match, sets on down match; code 3 inverts
// - Phase-correct sets overflow flag each time the counter reaches zero
// - A channel output reaches its pin only when its direction is output
// - Output mode codes shape outputs only; mode select alone shapes counting
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024
// - With top 0xFF phase-correct period is 510 ticks, fast PWM 256
// - A match sets its flag on the next tick; writing one clears it
// - A count write overrides counting and blocks matches on the next tick
// - Output code zero disconnects the channel and keeps normal port data
package tmw_pkg;
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PHASE_OCR = 3'h5;
  localparam logic [2:0] MODE_FAST_OCR  = 3'h7;
  localparam int         MODE_HI_BIT    = 2;

  localparam logic [1:0] OUT_OFF    = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR  = 2'h2;
  localparam logic [1:0] OUT_SET    = 2'h3;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  // clock select codes; anything else stops the timer
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  // terminal values of the divider (factor minus one)
  localparam logic [9:0] DIV8_LAST   = 10'h007;
  localparam logic [9:0] DIV64_LAST  = 10'h03F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1K_LAST  = 10'h3FF;
  localparam logic [9:0] DIV_ZERO    = 10'h000;
  localparam logic [9:0] DIV_ONE     = 10'h001;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } tmw_dir_e;

  typedef struct packed {
    logic [2:0] clkSel;
    logic [2:0] waveModeSel;
    logic [1:0] chanAOutMode;
    logic [1:0] chanBOutMode;
  } tmw_cfg_s;

  typedef struct packed {
    logic [9:0] div;
    logic       tick;
  } tmw_pre_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] ocrA;
    logic [7:0] ocrB;
    logic [7:0] ocrABuf;
    logic [7:0] ocrBBuf;
    tmw_dir_e   dir;
    logic       block;
    logic       ovf;
    logic       flagA;
    logic       flagB;
    logic       waveA;
    logic       waveB;
    logic       pinOutA;
    logic       pinOeA;
    logic       pinOutB;
    logic       pinOeB;
  } tmw_st_s;
endpackage

// >>> hdl/tmw_prescaler.sv
// timer tick generator: divides the clock by the selected prescale factor
`timescale 1ns/10ps
module tmw_prescaler
  import tmw_pkg::*;
(
  input  wire logic       clk,    // i/o clock
  input  wire logic       rst,    // synchronous reset, active high
  input  wire logic [2:0] clkSel, // prescale select
  output logic            tick    // one-cycle timer tick
);
  tmw_pre_s s_q;
  tmw_pre_s s_d;
  logic [9:0] last;

  always_comb begin
    last = DIV_ZERO;
    s_d = s_q;
    s_d.tick = 1'b0;
    unique case (clkSel)
      CS_DIV8:   last = DIV8_LAST;
      CS_DIV64:  last = DIV64_LAST;
      CS_DIV256: last = DIV256_LAST;
      CS_DIV1K:  last = DIV1K_LAST;
      default:   last = DIV_ZERO;
    endcase
    if (clkSel == CS_STOP || clkSel > CS_DIV1K) begin
      s_d.div = DIV_ZERO;
    end else if (s_q.div >= last) begin
      // divider restarts so a shorter factor takes effect at once
      s_d.div = DIV_ZERO;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + DIV_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// >>> hdl/tmw_timer.sv
// 8-bit timer with two compare channels and four waveform modes
`timescale 1ns/10ps
module tmw_timer
  import tmw_pkg::*;
(
  input  wire logic       clk,         // i/o clock, 250 MHz
  input  wire logic       rst,         // synchronous reset, active high
  input  tmw_cfg_s        cfg,         // clock, wave and output mode selects
  input  wire logic       countWr,     // write strobe for the counter
  input  wire logic [7:0] countWrData, // value written to the counter
  input  wire logic       cmpAWr,      // write strobe for compare A
  input  wire logic [7:0] cmpAWrData,  // value written to compare A
  input  wire logic       cmpBWr,      // write strobe for compare B
  input  wire logic [7:0] cmpBWrData,  // value written to compare B
  input  wire logic       ovfClr,      // write-one clear of overflow flag
  input  wire logic       matchAClr,   // write-one clear of match A flag
  input  wire logic       matchBClr,   // write-one clear of match B flag
  input  wire logic       pinDirA,     // pin A direction, high = output
  input  wire logic       pinDirB,     // pin B direction, high = output
  input  wire logic       portDataA,   // normal port data for pin A
  input  wire logic       portDataB,   // normal port data for pin B
  output logic [7:0]      countValue,  // current count
  output logic [7:0]      compareAValue, // active compare A
  output logic [7:0]      compareBValue, // active compare B
  output logic            overflowFlag,  // sticky overflow flag
  output logic            matchAFlag,    // sticky match A flag
  output logic            matchBFlag,    // sticky match B flag
  output logic            waveOutA,      // internal channel A level
  output logic            waveOutB,      // internal channel B level
  output logic            pinOutA,       // pin A output value
  output logic            pinOeA,        // pin A output enable
  output logic            pinOutB,       // pin B output value
  output logic            pinOeB         // pin B output enable
);
  tmw_st_s q;
  tmw_st_s d;
  logic       tick;
  logic [2:0] mode;
  logic       hiBit;
  logic       isClrMatch;
  logic       isFast;
  logic       isPhase;
  logic       isPwm;
  logic [7:0] topVal;
  logic       atTop;
  logic       phTop;
  logic       upEff;
  logic       bottomEv;
  logic       matchA;
  logic       matchB;
  logic       connA;
  logic       connB;

  tmw_prescaler u_pre (
    .clk    (clk),
    .rst    (rst),
    .clkSel (cfg.clkSel),
    .tick   (tick)
  );

  // counting shape comes from the mode select alone
  assign mode    = cfg.waveModeSel;
  assign hiBit   = mode[MODE_HI_BIT];
  assign isClrMatch = (mode == MODE_CLR_MATCH);
  assign isFast  = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_OCR);
  assign isPhase = (mode == MODE_PHASE_MAX) || (mode == MODE_PHASE_OCR);
  assign isPwm   = isFast || isPhase;
  assign topVal  = (mode == MODE_FAST_OCR || mode == MODE_PHASE_OCR || isClrMatch)
                   ? q.ocrA : CNT_MAX;
  assign atTop   = (q.count == topVal);
  // a count left above top by a write still turns at the 8-bit ceiling
  assign phTop   = atTop || (q.count == CNT_MAX);
  // bottom counts as up and top as down so the extreme compares stay steady
  assign upEff   = (q.count == CNT_BOTTOM) ? 1'b1 :
                   (phTop ? 1'b0 : (q.dir == DIR_UP));
  assign bottomEv = tick && isFast && atTop;
  // matches are dropped in the write cycle and on the tick after it
  assign matchA  = (q.count == q.ocrA) && !q.block && !countWr;
  assign matchB  = (q.count == q.ocrB) && !q.block && !countWr;
  // pwm code 1: output A only with the high mode bit, output B reserved
  assign connA   = (cfg.chanAOutMode != OUT_OFF) &&
                   !(isPwm && cfg.chanAOutMode == OUT_TOGGLE && !hiBit);
  assign connB   = (cfg.chanBOutMode != OUT_OFF) &&
                   !(isPwm && cfg.chanBOutMode == OUT_TOGGLE);

  // next level of one channel on a timer tick
  function automatic logic chanNext(
    input logic       cur,
    input logic [1:0] om,
    input logic       canToggle,
    input logic       match,
    input logic       fast,
    input logic       phase,
    input logic       bottom,
    input logic       ocrIsTop,
    input logic       up
  );
    logic nxt;
    nxt = cur;
    if (!fast && !phase) begin
      if (match) begin
        unique case (om)
          OUT_TOGGLE: nxt = !cur;
          OUT_CLEAR:  nxt = 1'b0;
          OUT_SET:    nxt = 1'b1;
          default:    nxt = cur;
        endcase
      end
    end else if (om == OUT_TOGGLE) begin
      if (canToggle && match) begin
        nxt = !cur;
      end
    end else if (om[1]) begin
      if (fast && bottom) begin
        nxt = (om == OUT_CLEAR);
      end else if (fast && match && !ocrIsTop) begin
        nxt = (om != OUT_CLEAR);
      end else if (phase && match) begin
        nxt = up ? (om != OUT_CLEAR) : (om == OUT_CLEAR);
      end
    end
    return nxt;
  endfunction

  always_comb begin
    d = q;
    // ovf holds only this tick's overflow event until the clear is merged below
    d.ovf = 1'b0;
    // compare writes: straight through in non-pwm modes, buffered in pwm
    if (cmpAWr) begin
      d.ocrABuf = cmpAWrData;
    end
    if (cmpBWr) begin
      d.ocrBBuf = cmpBWrData;
    end
    if (!isPwm) begin
      d.ocrA = d.ocrABuf;
      d.ocrB = d.ocrBBuf;
    end else if (tick && ((isFast && atTop) || (isPhase && phTop && q.dir == DIR_UP))) begin
      // buffer loads at the period boundary so no odd pulse appears
      d.ocrA = q.ocrABuf;
      d.ocrB = q.ocrBBuf;
    end

    if (tick) begin
      if (isPhase) begin
        if (q.dir == DIR_UP) begin
          if (phTop) begin
            // top is held for exactly this one tick
            d.dir = DIR_DOWN;
            d.count = (q.count == CNT_BOTTOM) ? CNT_BOTTOM : q.count - CNT_ONE;
          end else begin
            d.count = q.count + CNT_ONE;
          end
        end else if (q.count == CNT_BOTTOM) begin
          d.dir = DIR_UP;
          d.count = q.count + CNT_ONE;
          d.ovf = 1'b1;
        end else begin
          d.count = q.count - CNT_ONE;
        end
      end else if (isFast) begin
        d.dir = DIR_UP;
        if (atTop) begin
          d.count = CNT_BOTTOM;
          d.ovf = 1'b1;
        end else begin
          d.count = q.count + CNT_ONE;
        end
      end else begin
        d.dir = DIR_UP;
        // a compare below the count is passed by and met after the wrap
        // a match blocked by a counter write does not clear the count either
        if (isClrMatch && matchA) begin
          d.count = CNT_BOTTOM;
        end else begin
          d.count = q.count + CNT_ONE;
        end
        if (q.count == CNT_MAX) begin
          d.ovf = 1'b1;
        end
      end

      if (matchA) begin
        d.flagA = 1'b1;
      end
      if (matchB) begin
        d.flagB = 1'b1;
      end
      d.waveA = chanNext(q.waveA, cfg.chanAOutMode, hiBit, matchA, isFast, isPhase,
                         bottomEv, q.ocrA == topVal, upEff);
      d.waveB = chanNext(q.waveB, cfg.chanBOutMode, 1'b0, matchB, isFast, isPhase,
                         bottomEv, q.ocrB == topVal, upEff);
      d.block = 1'b0;
    end

    // software clears lose against a set in the same cycle
    d.ovf   = d.ovf || (q.ovf && !ovfClr);
    d.flagA = (tick && matchA) || (q.flagA && !matchAClr);
    d.flagB = (tick && matchB) || (q.flagB && !matchBClr);

    if (countWr) begin
      d.count = countWrData;
      d.block = 1'b1;
    end

    d.pinOutA = connA ? d.waveA : portDataA;
    d.pinOutB = connB ? d.waveB : portDataB;
    d.pinOeA  = pinDirA;
    d.pinOeB  = pinDirB;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{dir: DIR_UP, default: '0};
    end else begin
      q <= d;
    end
  end

  assign countValue    = q.count;
  assign compareAValue = q.ocrA;
  assign compareBValue = q.ocrB;
  assign overflowFlag  = q.ovf;
  assign matchAFlag    = q.flagA;
  assign matchBFlag    = q.flagB;
  assign waveOutA      = q.waveA;
  assign waveOutB      = q.waveB;
  assign pinOutA       = q.pinOutA;
  assign pinOeA        = q.pinOeA;
  assign pinOutB       = q.pinOutB;
  assign pinOeB        = q.pinOeB;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_ph_at_top;
    tick && isPhase && q.dir == DIR_UP && atTop && q.count != CNT_BOTTOM && !countWr;
  endsequence

  // top stands only from the tick that reached it to the next one
  sequence s_ph_leave_top;
    q.dir == DIR_DOWN && countValue != $past(q.count);
  endsequence

  a_normal_wrap: assert property (
    tick && mode == MODE_NORMAL && q.count == CNT_MAX && !countWr
    |=> countValue == CNT_BOTTOM && overflowFlag)
    else $error("normal mode did not wrap with overflow");

  a_match_clear: assert property (
    tick && isClrMatch && matchA && q.count != CNT_MAX
    |=> countValue == CNT_BOTTOM && (!overflowFlag || $past(q.ovf)))
    else $error("clear-on-match mode did not clear on compare A");

  a_match_toggle: assert property (
    tick && isClrMatch && cfg.chanAOutMode == OUT_TOGGLE && matchA
    |=> waveOutA != $past(waveOutA) && matchAFlag)
    else $error("clear-on-match toggle or flag missing");

  a_fast_wrap: assert property (
    tick && isFast && atTop && !countWr
    |=> countValue == CNT_BOTTOM && overflowFlag && waveOutA == (
        $past(cfg.chanAOutMode) == OUT_CLEAR ? 1'b1 :
        $past(cfg.chanAOutMode) == OUT_SET ? 1'b0 :
        $past(waveOutA) ^ ($past(cfg.chanAOutMode) == OUT_TOGGLE && $past(hiBit && matchA))))
    else $error("fast pwm top handling wrong");

  a_fast_match: assert property (
    tick && isFast && matchB && q.ocrB != topVal && !atTop && cfg.chanBOutMode == OUT_CLEAR
    |=> !waveOutB)
    else $error("fast pwm non-inverting match did not clear");

  a_phase_hold: assert property (
    s_ph_at_top |=> (countValue == $past(q.count) - CNT_ONE) && q.dir == DIR_DOWN)
    else $error("phase-correct top not left downward");

  a_phase_top_once: assert property (
    s_ph_at_top |=> s_ph_leave_top)
    else $error("phase-correct top held more than one tick");

  a_phase_bottom: assert property (
    tick && isPhase && q.dir == DIR_DOWN && q.count == CNT_BOTTOM && !countWr
    |=> overflowFlag && countValue == CNT_ONE && q.dir == DIR_UP)
    else $error("phase-correct bottom missing overflow");

  a_pin_gate: assert property (
    !pinDirA |=> !pinOeA ##1 !$past(pinDirA) || pinOeA)
    else $error("pin A driven without output direction");

  a_port_pass: assert property (
    cfg.chanBOutMode == OUT_OFF |=> pinOutB == $past(portDataB))
    else $error("disconnected channel overrode port data");

  a_write_block: assert property (
    countWr ##1 (tick && !countWr && q.count == q.ocrA && !matchAFlag && !matchAClr)
    |=> !matchAFlag)
    else $error("match not blocked after counter write");

  a_tick_only: assert property (
    !tick && !countWr |=> $stable(countValue) && $stable(waveOutA) && $stable(waveOutB))
    else $error("counter or output moved without a tick");

  a_flag_set_wins: assert property (
    tick && matchA && matchAClr |=> matchAFlag)
    else $error("match flag set lost to a clear");

  a_flag_clear: assert property (
    matchAClr && !(tick && matchA) |=> !matchAFlag)
    else $error("match A flag not cleared by write-one");

  a_flag_b_set: assert property (
    tick && matchB |=> matchBFlag)
    else $error("match B flag not set on match");

  a_direct_load: assert property (
    !isPwm && cmpAWr |=> compareAValue == $past(cmpAWrData))
    else $error("unbuffered compare A write did not take effect");

  a_buffer_hold: assert property (
    isPwm && !(tick && ((isFast && atTop) || (isPhase && phTop && q.dir == DIR_UP)))
    |=> $stable(compareAValue))
    else $error("buffered compare A changed off the period boundary");

  a_b_no_toggle: assert property (
    isPwm && cfg.chanBOutMode == OUT_TOGGLE |=> pinOutB == $past(portDataB))
    else $error("pwm toggle code drove pin B");

  a_tick_gap: assert property (
    tick && cfg.clkSel != CS_DIV1 |=> !tick)
    else $error("prescaled tick lasted more than one cycle");

  a_count_load: assert property (
    countWr |=> countValue == $past(countWrData))
    else $error("counter write did not override counting");

  a_normal_step: assert property (
    tick && mode == MODE_NORMAL && !countWr
    |=> countValue == $past(q.count) + CNT_ONE)
    else $error("normal mode count step wrong");

  a_fast_up: assert property (
    tick && isFast && !atTop && !countWr
    |=> countValue == $past(q.count) + CNT_ONE)
    else $error("fast pwm up-count step wrong");

  a_phase_up: assert property (
    tick && isPhase && q.dir == DIR_UP && !phTop && !countWr
    |=> countValue == $past(q.count) + CNT_ONE)
    else $error("phase-correct up-count step wrong");

  a_phase_down: assert property (
    tick && isPhase && q.dir == DIR_DOWN && q.count != CNT_BOTTOM && !countWr
    |=> countValue == $past(q.count) - CNT_ONE)
    else $error("phase-correct down-count step wrong");
endmodule

// >>> verif/tmw_timer_test.sv
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/10ps
module tmw_timer_test
  import tmw_pkg::*;
  ;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  tmw_cfg_s   cfg;
  logic       countWr, cmpAWr, cmpBWr, ovfClr, matchAClr, matchBClr;
  logic [7:0] wrData;
  logic       pinDirA, pinDirB, portDataA, portDataB;
  logic [7:0] countValue, compareAValue, compareBValue;
  logic       overflowFlag, matchAFlag, matchBFlag;
  logic       waveOutA, waveOutB, pinOutA, pinOeA, pinOutB, pinOeB;
  int         errTotal = 0;
  int         checked  = 0;
  int         cycles   = 0;
  int         hiA, hiB, nTv, maxC, togA;
  logic       prevA;
  logic [7:0] c0, dc;
  int         divs [4] = '{8, 64, 256, 1024};

  tmw_timer u_dut (
    .clk(clk), .rst(rst), .cfg(cfg),
    .countWr(countWr), .countWrData(wrData),
    .cmpAWr(cmpAWr), .cmpAWrData(wrData),
    .cmpBWr(cmpBWr), .cmpBWrData(wrData),
    .ovfClr(ovfClr), .matchAClr(matchAClr), .matchBClr(matchBClr),
    .pinDirA(pinDirA), .pinDirB(pinDirB),
    .portDataA(portDataA), .portDataB(portDataB),
    .countValue(countValue), .compareAValue(compareAValue),
    .compareBValue(compareBValue), .overflowFlag(overflowFlag),
    .matchAFlag(matchAFlag), .matchBFlag(matchBFlag),
    .waveOutA(waveOutA), .waveOutB(waveOutB),
    .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB)
  );

  always #2 clk = ~clk;

  // ceiling is about three times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errTotal++;
      testDone();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write strobe (0 count, 1 compare A, 2 compare B); the write has landed on return
  task automatic wr(input int which, input logic [7:0] v);
    @(negedge clk);
    wrData  = v;
    countWr = (which == 0);
    cmpAWr  = (which == 1);
    cmpBWr  = (which == 2);
    @(negedge clk);
    countWr = 1'h0;
    cmpAWr  = 1'h0;
    cmpBWr  = 1'h0;
  endtask

  // write-one flag clear (0 overflow, 1 match A, 2 match B)
  task automatic clr(input int which);
    @(negedge clk);
    ovfClr    = (which == 0);
    matchAClr = (which == 1);
    matchBClr = (which == 2);
    @(negedge clk);
    ovfClr    = 1'h0;
    matchAClr = 1'h0;
    matchBClr = 1'h0;
  endtask

  task automatic waitCount(input logic [7:0] v);
    int i;
    i = 0;
    while (countValue !== v && i < 1100) begin
      @(negedge clk);
      i++;
    end
    chk("count reached", countValue, v);
  endtask

  // tallies output levels and count statistics over n settled samples
  task automatic run(input int n, input logic [7:0] tv);
    hiA   = 0;
    hiB   = 0;
    nTv   = 0;
    maxC  = 0;
    togA  = 0;
    prevA = waveOutA;
    repeat (n) begin
      @(negedge clk);
      hiA += waveOutA;
      hiB += waveOutB;
      nTv += (countValue === tv);
      togA += (waveOutA !== prevA);
      prevA = waveOutA;
      if (countValue > maxC) maxC = countValue;
    end
  endtask

  task automatic testDone;
    $display("comparisons %0d, mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    cfg = '0;
    cfg.clkSel = CS_DIV1;
    {countWr, cmpAWr, cmpBWr, ovfClr, matchAClr, matchBClr} = 6'h00;
    wrData = 8'h00;
    {pinDirA, pinDirB, portDataA, portDataB} = 4'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    chk("reset state", {countValue, overflowFlag, matchAFlag, waveOutA, pinOeA}, 16'h0000);
    step(3);
    wr(0, 8'hFE);
    step(1);
    chk("count", countValue, 8'hFF);
    chk("overflow", overflowFlag, 1'h0);
    step(1);
    chk("count", countValue, 8'h00);
    chk("overflow", overflowFlag, 1'h1);
    step(1);
    chk("overflow", overflowFlag, 1'h1);
    clr(0);
    chk("overflow", overflowFlag, 1'h0);
    $display("normal counting done");

    cfg.waveModeSel = MODE_CLR_MATCH;
    cfg.chanAOutMode = OUT_TOGGLE;
    pinDirA = 1'h1;
    wr(1, 8'h05);
    step(2);
    chk("compare A", compareAValue, 8'h05);
    clr(1);
    wr(0, 8'h00);
    run(18, 8'h05);
    chk("max count", maxC, 8'h05);
    chk("top hits", nTv, 3);
    chk("toggles A", togA, 3);
    chk("match A flag", matchAFlag, 1'h1);
    chk("pin A enable", pinOeA, 1'h1);
    clr(1);
    wr(0, 8'h05);
    step(1);
    chk("count", countValue, 8'h06);
    chk("match A flag", matchAFlag, 1'h0);
    wr(1, 8'h02);
    waitCount(8'hFF);
    chk("overflow", overflowFlag, 1'h0);
    step(1);
    chk("count", countValue, 8'h00);
    chk("overflow", overflowFlag, 1'h1);
    step(2);
    chk("count", countValue, 8'h02);
    step(1);
    chk("count", countValue, 8'h00);
    cfg.chanAOutMode = OUT_OFF;
    portDataA = 1'h1;
    pinDirA = 1'h0;
    step(2);
    chk("pin A value", pinOutA, 1'h1);
    chk("pin A enable", pinOeA, 1'h0);
    pinDirA = 1'h1;
    portDataA = 1'h0;
    cfg.chanAOutMode = OUT_SET;
    step(8);
    chk("pin A value", pinOutA, 1'h1);
    chk("pin A enable", pinOeA, 1'h1);
    $display("clear-on-match done");

    cfg.waveModeSel = MODE_FAST_MAX;
    cfg.chanAOutMode = OUT_CLEAR;
    cfg.chanBOutMode = OUT_SET;
    wr(1, 8'h80);
    wr(2, 8'h40);
    waitCount(8'hFF);
    step(1);
    chk("compare A", compareAValue, 8'h80);
    chk("compare B", compareBValue, 8'h40);
    run(256, 8'h00);
    chk("bottom hits", nTv, 1);
    chk("max count", maxC, 8'hFF);
    chk("high A", hiA, 129);
    chk("high B", hiB, 191);
    clr(0);
    clr(2);
    chk("match B flag", matchBFlag, 1'h0);
    waitCount(8'hF0);
    chk("overflow", overflowFlag, 1'h0);
    chk("match B flag", matchBFlag, 1'h1);
    waitCount(8'h10);
    chk("overflow", overflowFlag, 1'h1);
    wr(1, 8'h20);
    step(1);
    chk("compare A", compareAValue, 8'h80);
    waitCount(8'h01);
    chk("compare A", compareAValue, 8'h20);
    wr(1, 8'h00);
    waitCount(8'hFF);
    step(1);
    run(512, 8'h00);
    chk("high A", hiA, 2);
    wr(1, 8'hFF);
    waitCount(8'hFF);
    step(1);
    run(256, 8'h00);
    chk("high A", hiA, 256);
    cfg.waveModeSel = MODE_FAST_OCR;
    cfg.chanAOutMode = OUT_TOGGLE;
    cfg.chanBOutMode = OUT_TOGGLE;
    portDataB = 1'h1;
    pinDirB = 1'h1;
    wr(1, 8'h09);
    waitCount(8'hFF);
    step(2);
    run(40, 8'h09);
    chk("max count", maxC, 8'h09);
    chk("top hits", nTv, 4);
    chk("toggles A", togA, 4);
    chk("pin B value", pinOutB, 1'h1);
    chk("pin B enable", pinOeB, 1'h1);
    cfg.waveModeSel = MODE_FAST_MAX;
    portDataA = 1'h1;
    step(2);
    chk("pin A value", pinOutA, 1'h1);
    portDataA = 1'h0;
    step(2);
    chk("pin A value", pinOutA, 1'h0);
    $display("fast pwm done");

    cfg.waveModeSel = MODE_PHASE_MAX;
    cfg.chanAOutMode = OUT_CLEAR;
    cfg.chanBOutMode = OUT_SET;
    wr(1, 8'h40);
    step(1020);
    waitCount(8'hFF);
    run(510, 8'hFF);
    chk("top hits", nTv, 1);
    chk("max count", maxC, 8'hFF);
    chk("high A", hiA, 128);
    chk("high B", hiB, 382);
    waitCount(8'hFF);
    clr(0);
    waitCount(8'h01);
    chk("overflow", overflowFlag, 1'h0);
    step(2);
    chk("count", countValue, 8'h01);
    chk("overflow", overflowFlag, 1'h1);
    cfg.waveModeSel = MODE_PHASE_OCR;
    wr(1, 8'h0A);
    step(600);
    run(40, 8'h0A);
    chk("max count", maxC, 8'h0A);
    chk("top hits", nTv, 2);
    $display("phase-correct pwm done");

    cfg.waveModeSel = MODE_NORMAL;
    for (int k = 0; k < 4; k++) begin
      cfg.clkSel = CS_DIV8 + 3'(k);
      step(divs[k] + 2);
      c0 = countValue;
      step(2 * divs[k]);
      dc = countValue - c0;
      chk("prescaled ticks", dc, 8'h02);
    end
    $display("prescaler done");
    testDone();
  end
endmodule
